// ==== rtl/csalu_defs.svh ====
// Constants for the command streamer ALU: offsets, fields, encodings, reset values.
`ifndef CSALU_DEFS_SVH
`define CSALU_DEFS_SVH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define CSALU_OPC_MSB 31
`define CSALU_OPC_LSB 20
`define CSALU_OP1_MSB 19
`define CSALU_OP1_LSB 10
`define CSALU_OP2_MSB 9
`define CSALU_OP2_LSB 0
`define CSALU_PREFIX_BIT 10
`define CSALU_GROUP_MSB 9
`define CSALU_GROUP_LSB 7
`define CSALU_SUB_MSB 6
`define CSALU_SUB_LSB 0

// ----------------------------------------------------------------
// Opcode groups and sub-opcodes
// ----------------------------------------------------------------
`define CSALU_GRP_NOOP 3'h0
`define CSALU_GRP_LOAD 3'h1
`define CSALU_GRP_ARITH 3'h2
`define CSALU_GRP_STORE 3'h3
`define CSALU_SUB_LOAD_REG 7'h00
`define CSALU_SUB_LOAD_CONST 7'h01
`define CSALU_SUB_ADD 7'h00
`define CSALU_SUB_SUB 7'h01
`define CSALU_SUB_AND 7'h02
`define CSALU_SUB_OR 7'h03
`define CSALU_SUB_XOR 7'h04
`define CSALU_SUB_STORE 7'h00

// ----------------------------------------------------------------
// Operand encodings
// ----------------------------------------------------------------
`define CSALU_OPND_A 10'h020
`define CSALU_OPND_B 10'h021
`define CSALU_OPND_RESULT 10'h031
`define CSALU_OPND_ZERO 10'h032
`define CSALU_OPND_CARRY 10'h033

// ----------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------
`define CSALU_GPR_LAST 8'h7c
`define CSALU_RESULT_LO 8'h80
`define CSALU_RESULT_HI 8'h84
`define CSALU_FLAGS 8'h88
`define CSALU_COUNT 8'h8c
`define CSALU_OPA_LO 8'h90
`define CSALU_OPA_HI 8'h94
`define CSALU_OPB_LO 8'h98
`define CSALU_OPB_HI 8'h9c
`define CSALU_FLAG_ZERO_BIT 0
`define CSALU_FLAG_CARRY_BIT 1
`define CSALU_RESET_64 64'h0000_0000_0000_0000

`endif

// ==== rtl/csalu_pkg.sv ====
// Types shared by the command streamer ALU files.
package csalu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_BUS_WR,
        ST_BUS_RD,
        ST_BUS_DONE
    } csalu_state_type;
endpackage

// ==== rtl/csalu_gpr_mem.sv ====
// General register storage: sixteen 64-bit words, per-half write, registered read.
`timescale 1ns/1ps
`default_nettype none
`include "csalu_defs.svh"
module csalu_gpr_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 64,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    input wire logic we_lo,
    input wire logic we_hi,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // ----------------------------------------------------------------
    // Storage, one slot per entry
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[gi] <= '0;
                end else if (wr_addr == AW'(gi)) begin
                    if (we_lo) begin
                        mem_r[gi][WIDTH/2-1:0] <= wr_data[WIDTH/2-1:0];
                    end
                    if (we_hi) begin
                        mem_r[gi][WIDTH-1:WIDTH/2] <= wr_data[WIDTH-1:WIDTH/2];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Read returns the value before any same-cycle write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/csalu_top.sv ====
// Command streamer ALU: instruction decode, datapath and AHB-Lite register slave.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csalu_defs.svh"
module csalu_top #(
    parameter int GPR_COUNT = 16,
    parameter int DATA_W = 64
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    output logic instr_ready
);
    localparam int AW = 4;
    localparam int HALF = DATA_W / 2;

    csalu_pkg::csalu_state_type state_r;
    csalu_pkg::csalu_state_type state_nxt;

    // ----------------------------------------------------------------
    // Instruction fields
    // ----------------------------------------------------------------
    logic [11:0] opc;
    logic prefix;
    logic [2:0] group;
    logic [6:0] sub;
    logic [9:0] opnd1;
    logic [9:0] opnd2;

    assign opc = instr_word[`CSALU_OPC_MSB:`CSALU_OPC_LSB];
    assign opnd1 = instr_word[`CSALU_OP1_MSB:`CSALU_OP1_LSB];
    assign opnd2 = instr_word[`CSALU_OP2_MSB:`CSALU_OP2_LSB];
    assign prefix = opc[`CSALU_PREFIX_BIT];
    assign group = opc[`CSALU_GROUP_MSB:`CSALU_GROUP_LSB];
    assign sub = opc[`CSALU_SUB_MSB:`CSALU_SUB_LSB];

    // ----------------------------------------------------------------
    // Bus and instruction acceptance
    // ----------------------------------------------------------------
    logic bus_take;
    logic bus_rd_take;
    logic fire;

    // Only the read data phase stretches; every other state can take a transfer
    assign hreadyout = (state_r != csalu_pkg::ST_BUS_RD);
    assign hresp = 1'b0;
    assign bus_take = hsel && htrans[1] && hready && hreadyout;
    assign bus_rd_take = bus_take && !hwrite;
    // Bus wins a tie so register commands never starve behind a long program
    assign instr_ready = (state_r == csalu_pkg::ST_IDLE) && !bus_take;
    assign fire = instr_valid && instr_ready;

    // ----------------------------------------------------------------
    // Decode; anything not matched falls through as a no-op
    // ----------------------------------------------------------------
    logic dst_is_op;
    logic do_load;
    logic do_const;
    logic do_arith;
    logic do_store;
    logic store_src_ok;

    assign dst_is_op = (opnd1 == `CSALU_OPND_A) || (opnd1 == `CSALU_OPND_B);
    assign store_src_ok = (opnd2 == `CSALU_OPND_RESULT) || (opnd2 == `CSALU_OPND_ZERO)
        || (opnd2 == `CSALU_OPND_CARRY);

    always_comb begin
        do_load = 1'b0;
        do_const = 1'b0;
        do_arith = 1'b0;
        do_store = 1'b0;
        if (fire && !opc[11]) begin
            case (group)
                `CSALU_GRP_NOOP: begin
                    do_load = 1'b0;
                end
                `CSALU_GRP_LOAD: begin
                    do_load = (sub == `CSALU_SUB_LOAD_REG) && dst_is_op
                        && (opnd2[9:4] == 6'h00);
                    do_const = (sub == `CSALU_SUB_LOAD_CONST) && dst_is_op;
                end
                `CSALU_GRP_ARITH: begin
                    do_arith = !prefix && (sub <= `CSALU_SUB_XOR);
                end
                `CSALU_GRP_STORE: begin
                    do_store = (sub == `CSALU_SUB_STORE) && (opnd1[9:4] == 6'h00)
                        && store_src_ok;
                end
                default: begin
                    do_store = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            csalu_pkg::ST_BUS_RD: begin
                state_nxt = csalu_pkg::ST_BUS_DONE;
            end
            csalu_pkg::ST_IDLE, csalu_pkg::ST_LOAD, csalu_pkg::ST_BUS_WR,
            csalu_pkg::ST_BUS_DONE: begin
                if (bus_take) begin
                    state_nxt = hwrite ? csalu_pkg::ST_BUS_WR : csalu_pkg::ST_BUS_RD;
                end else if (do_load) begin
                    state_nxt = csalu_pkg::ST_LOAD;
                end else begin
                    state_nxt = csalu_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = csalu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= csalu_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Captured bus address phase
    // ----------------------------------------------------------------
    logic [7:0] bus_addr_r;
    logic bus_in_map_r;
    logic bus_is_gpr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_addr_r <= 8'h00;
            bus_in_map_r <= 1'b0;
        end else if (bus_take) begin
            bus_addr_r <= {haddr[7:2], 2'b00};
            bus_in_map_r <= (haddr[31:8] == 24'h000000);
        end
    end

    assign bus_is_gpr = bus_in_map_r && (bus_addr_r <= `CSALU_GPR_LAST);

    // ----------------------------------------------------------------
    // Captured load destination
    // ----------------------------------------------------------------
    logic ld_to_b_r;
    logic ld_inv_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_to_b_r <= 1'b0;
            ld_inv_r <= 1'b0;
        end else if (do_load) begin
            ld_to_b_r <= (opnd1 == `CSALU_OPND_B);
            ld_inv_r <= prefix;
        end
    end

    // ----------------------------------------------------------------
    // General register storage
    // ----------------------------------------------------------------
    logic mem_rd_en;
    logic [AW-1:0] mem_rd_addr;
    logic [DATA_W-1:0] mem_rd_data;
    logic mem_we_lo;
    logic mem_we_hi;
    logic [AW-1:0] mem_wr_addr;
    logic [DATA_W-1:0] mem_wr_data;
    logic [DATA_W-1:0] store_val;
    logic bus_wr_now;

    assign mem_rd_en = bus_rd_take || do_load;
    assign mem_rd_addr = bus_rd_take ? haddr[6:3] : opnd2[AW-1:0];
    assign bus_wr_now = (state_r == csalu_pkg::ST_BUS_WR) && bus_is_gpr;

    // Each general register takes two words, low half first
    always_comb begin
        mem_we_lo = 1'b0;
        mem_we_hi = 1'b0;
        mem_wr_addr = opnd1[AW-1:0];
        mem_wr_data = store_val;
        if (bus_wr_now) begin
            mem_we_lo = !bus_addr_r[2];
            mem_we_hi = bus_addr_r[2];
            mem_wr_addr = bus_addr_r[6:3];
            mem_wr_data = {hwdata, hwdata};
        end else if (do_store) begin
            mem_we_lo = 1'b1;
            mem_we_hi = 1'b1;
        end
    end

    csalu_gpr_mem #(
        .DEPTH(GPR_COUNT),
        .WIDTH(DATA_W),
        .AW(AW)
    ) u_gpr (
        .clk(hclk),
        .rst_n(hresetn),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data),
        .we_lo(mem_we_lo),
        .we_hi(mem_we_hi),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data)
    );

    // ----------------------------------------------------------------
    // Operand registers
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] operand_a_reg_r;
    logic [DATA_W-1:0] operand_b_reg_r;
    logic [DATA_W-1:0] load_val;

    assign load_val = ld_inv_r ? ~mem_rd_data : mem_rd_data;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand_a_reg_r <= `CSALU_RESET_64;
            operand_b_reg_r <= `CSALU_RESET_64;
        end else if (state_r == csalu_pkg::ST_LOAD) begin
            if (ld_to_b_r) begin
                operand_b_reg_r <= load_val;
            end else begin
                operand_a_reg_r <= load_val;
            end
        end else if (do_const) begin
            if (opnd1 == `CSALU_OPND_B) begin
                operand_b_reg_r <= {DATA_W{prefix}};
            end else begin
                operand_a_reg_r <= {DATA_W{prefix}};
            end
        end
    end

    // ----------------------------------------------------------------
    // Arithmetic and logic
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] result_register_r;
    logic zero_flag_r;
    logic carry_flag_r;
    logic [DATA_W:0] alu_out;

    // Subtract carry is the borrow out of A minus B
    always_comb begin
        case (sub)
            `CSALU_SUB_ADD: alu_out = {1'b0, operand_a_reg_r} + {1'b0, operand_b_reg_r};
            `CSALU_SUB_SUB: alu_out = {1'b0, operand_a_reg_r} - {1'b0, operand_b_reg_r};
            `CSALU_SUB_AND: alu_out = {1'b0, operand_a_reg_r & operand_b_reg_r};
            `CSALU_SUB_OR: alu_out = {1'b0, operand_a_reg_r | operand_b_reg_r};
            `CSALU_SUB_XOR: alu_out = {1'b0, operand_a_reg_r ^ operand_b_reg_r};
            default: alu_out = {1'b0, result_register_r};
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_register_r <= `CSALU_RESET_64;
            zero_flag_r <= 1'b0;
            carry_flag_r <= 1'b0;
        end else if (do_arith) begin
            result_register_r <= alu_out[DATA_W-1:0];
            zero_flag_r <= (alu_out[DATA_W-1:0] == '0);
            carry_flag_r <= alu_out[DATA_W];
        end
    end

    // ----------------------------------------------------------------
    // Store source
    // ----------------------------------------------------------------
    always_comb begin
        case (opnd2)
            `CSALU_OPND_ZERO: store_val = {DATA_W{zero_flag_r}};
            `CSALU_OPND_CARRY: store_val = {DATA_W{carry_flag_r}};
            default: store_val = result_register_r;
        endcase
        if (prefix) begin
            store_val = ~store_val;
        end
    end

    // ----------------------------------------------------------------
    // Executed instruction count, visible to software
    // ----------------------------------------------------------------
    logic [31:0] exec_count_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_count_r <= 32'h0000_0000;
        end else if (fire) begin
            exec_count_r <= exec_count_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    // Unmapped addresses read as zero; writes to them are dropped
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (bus_is_gpr) begin
            rd_mux = bus_addr_r[2] ? mem_rd_data[DATA_W-1:HALF] : mem_rd_data[HALF-1:0];
        end else if (bus_in_map_r) begin
            case (bus_addr_r)
                `CSALU_RESULT_LO: rd_mux = result_register_r[HALF-1:0];
                `CSALU_RESULT_HI: rd_mux = result_register_r[DATA_W-1:HALF];
                `CSALU_FLAGS: begin
                    rd_mux[`CSALU_FLAG_ZERO_BIT] = zero_flag_r;
                    rd_mux[`CSALU_FLAG_CARRY_BIT] = carry_flag_r;
                end
                `CSALU_COUNT: rd_mux = exec_count_r;
                `CSALU_OPA_LO: rd_mux = operand_a_reg_r[HALF-1:0];
                `CSALU_OPA_HI: rd_mux = operand_a_reg_r[DATA_W-1:HALF];
                `CSALU_OPB_LO: rd_mux = operand_b_reg_r[HALF-1:0];
                `CSALU_OPB_HI: rd_mux = operand_b_reg_r[DATA_W-1:HALF];
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (state_r == csalu_pkg::ST_BUS_RD) begin
            hrdata <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// ==== tb/csalu_top_sva.sv ====
// Checker for the ALU bus and instruction handshakes.
`timescale 1ns/1ps
`default_nettype none
module csalu_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic instr_ready
);
    logic take;
    logic rdt;
    logic ld_take;
    assign take = hsel && htrans[1] && hready && hreadyout;
    assign rdt = take && !hwrite;
    // Register loads only: constant loads do not stall
    assign ld_take = instr_valid && instr_ready && !instr_word[31] &&
        instr_word[29:11] == 19'h10010 && instr_word[9:4] == 6'h0;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ----
    // Sequences and properties
    // ----
    sequence rd_take_s;
        rdt;
    endsequence
    sequence rd_answer_s;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence quiet_s;
        (!hsel && !instr_valid) [*4];
    endsequence
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (rd_take_s |=> rd_answer_s)
        else $error("read wait state wrong");
    write_wait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    unmapped_zero_a: assert property (rd_take_s ##0 |haddr[31:8] |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(rdt) || $past(rdt, 2))
        else $error("read data moved without a read");
    bus_block_a: assert property (take |-> !instr_ready)
        else $error("instruction taken beside bus transfer");
    load_stall_a: assert property (ld_take |=> !instr_ready)
        else $error("no idle cycle after load");
    idle_ready_a: assert property (quiet_s |-> instr_ready)
        else $error("instruction port stuck");
endmodule
bind csalu_top csalu_top_sva u_csalu_top_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready)
);
`default_nettype wire

// ==== tb/csalu_parser_model.sv ====
// Parser stand-in that offers instruction dwords to the ALU.
`timescale 1ns/1ps
`default_nettype none
module csalu_parser_model (
    input wire logic hclk,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [31:0] instr_word
);
    logic rdy_s;
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'hffff_ffff;
    end
    // ----
    // Issue
    // ----
    // Mid-cycle sample so the edge test never races the design
    always @(negedge hclk) rdy_s = instr_ready;
    // Whole dword held until taken; idle word inverted, never stale
    task automatic issue(input logic [31:0] w, input logic [31:0] gap);
        repeat (gap) @(posedge hclk);
        @(posedge hclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        instr_valid <= 1'b0;
        instr_word <= ~w;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the command streamer ALU.
`timescale 1ns/1ps
`default_nettype none
`include "csalu_defs.svh"
module testbench;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic instr_valid;
    logic [31:0] instr_word;
    logic instr_ready;
    logic rdy_s;
    logic rd_ph;
    logic [31:0] hrd_s;
    logic [31:0] seed;
    logic [31:0] exp_q [$];
    int miscompares;
    int n_checks;
    int cyc;
    logic [63:0] g [16];
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] acc;
    logic zero_flag;
    logic carry_flag;
    logic [31:0] cnt;
    localparam logic [31:0] NOPS [7] = '{32'h0, 32'h1050_0000, 32'h5000_0000,
        32'h8800_8003, 32'h0800_8803, 32'h1800_0830, 32'h0800_8010};
    csalu_top u_csalu_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready)
    );
    csalu_parser_model u_csalu_parser_model (
        .hclk(hclk), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word)
    );
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // ----
    // Helpers
    // ----
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] e);
        n_checks++;
        if (got !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t read %h expected %h", $time, got, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= ad;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (rdy_s !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, ad, 32'h0);
    endtask
    task automatic rd64(input logic [7:0] ad, input logic [63:0] e);
        rd({24'h0, ad}, e[31:0]);
        rd({24'h0, ad + 8'h4}, e[63:32]);
    endtask
    task automatic wr64(input logic [3:0] n, input logic [63:0] v);
        bus(1'b1, {25'h0, n, 3'h0}, v[31:0]);
        bus(1'b1, {25'h0, n, 3'h4}, v[63:32]);
        g[n] = v;
    endtask
    task automatic chk_state();
        rd64(`CSALU_RESULT_LO, acc);
        rd64(`CSALU_FLAGS, {cnt, 30'h0, carry_flag, zero_flag});
        rd64(`CSALU_OPA_LO, a);
        rd64(`CSALU_OPB_LO, b);
    endtask
    task automatic exec(input logic [31:0] w);
        logic [11:0] op;
        logic [9:0] o1;
        logic [9:0] o2;
        logic [64:0] s;
        logic [63:0] v;
        op = w[31:20];
        o1 = w[19:10];
        o2 = w[9:0];
        u_csalu_parser_model.issue(w, rnd() % 32'd3);
        cnt = cnt + 32'h1;
        v = (op[9:0] == 10'h080) ? g[o2[3:0]] : 64'h0;
        v = op[10] ? ~v : v;
        if (!op[11] && (o1 == `CSALU_OPND_A || o1 == `CSALU_OPND_B) &&
            (op[9:0] == 10'h081 || op[9:0] == 10'h080 && o2 < 10'h10)) begin
            if (o1[0])
                b = v;
            else
                a = v;
        end
        case (op)
            12'h100: s = {1'b0, a} + {1'b0, b};
            12'h101: s = {a < b, a - b};
            12'h102: s = {1'b0, a & b};
            12'h103: s = {1'b0, a | b};
            12'h104: s = {1'b0, a ^ b};
            default: s = {carry_flag, acc};
        endcase
        zero_flag = (op >= 12'h100 && op <= 12'h104) ? s[63:0] == 64'h0 : zero_flag;
        {carry_flag, acc} = s;
        v = {64{o2 == `CSALU_OPND_ZERO ? zero_flag : carry_flag}};
        v = (o2 == `CSALU_OPND_RESULT) ? acc : v;
        v = op[10] ? ~v : v;
        if (!op[11] && op[9:0] == 10'h180 && o1 < 10'h10 && o2 >= `CSALU_OPND_RESULT &&
            o2 <= `CSALU_OPND_CARRY)
            g[o1[3:0]] = v;
        repeat (2) @(posedge hclk);
    endtask
    // ----
    // Read monitor and timeout
    // ----
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        hrd_s = hrdata;
    end
    always @(posedge hclk) begin
        if (rd_ph && rdy_s)
            cmp(hrd_s, exp_q.pop_front());
        rd_ph <= (hsel && htrans[1] && rdy_s && !hwrite) || (rd_ph && !rdy_s);
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, rd_ph, zero_flag, carry_flag} = 6'h0;
        {haddr, hwdata, cnt} = 96'h0;
        htrans = 2'b00;
        {a, b, acc} = 192'h0;
        g = '{default: 64'h0};
        seed = 32'h10626b91;
        {miscompares, n_checks, cyc} = 96'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_state();
        rd(32'h0000_1000, 32'h0);
        bus(1'b1, {24'h0, `CSALU_RESULT_LO}, 32'h5a5a_5a5a);
        rd64(`CSALU_RESULT_LO, 64'h0);
        for (int i = 0; i < 16; i++)
            wr64(4'(i), {rnd(), rnd()});
        for (int i = 0; i < 16; i++)
            rd64(8'(i * 8), g[i]);
        $display("test registers done");
        exec({12'h080, `CSALU_OPND_A, 10'h3});
        exec({12'h480, `CSALU_OPND_B, 10'hf});
        chk_state();
        exec({12'h081, `CSALU_OPND_A, 10'h3ff});
        exec({12'h481, `CSALU_OPND_B, 10'h155});
        chk_state();
        wr64(4'h1, 64'h1);
        exec({12'h080, `CSALU_OPND_B, 10'h1});
        exec({12'h481, `CSALU_OPND_A, 10'h0});
        exec({12'h100, 20'h0});
        chk_state();
        exec({12'h081, `CSALU_OPND_A, 10'h0});
        exec({12'h101, 20'hfffff});
        chk_state();
        $display("test loads and carry done");
        for (int k = 0; k < 5; k++) begin
            exec({12'h080, `CSALU_OPND_A, 6'h0, 4'(rnd())});
            exec({12'h480, `CSALU_OPND_B, 6'h0, 4'(rnd())});
            exec({12'h100 + 12'(k), 20'(rnd())});
            chk_state();
            for (int j = 0; j < 6; j++)
                exec({j < 3 ? 12'h180 : 12'h580, 10'(8 + j), 10'h31 + 10'(j % 3)});
            for (int j = 8; j < 14; j++)
                rd64(8'(j * 8), g[j]);
        end
        $display("test operations done");
        for (int k = 0; k < 7; k++)
            exec(NOPS[k]);
        chk_state();
        rd64(8'h10, g[2]);
        $display("test no-ops done");
        repeat (4) @(posedge hclk);
        complete_run();
    end
endmodule
`default_nettype wire
